// file: hw/trigger_arm_delay_sequencer.sv
// Arm, trigger, start-delay and stop-delay sequencer with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "trig_seq_regs.svh"
module trigger_arm_delay_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        trigger_in,
  output logic             acquisition_ready_out,
  output logic             trigger_out,
  output logic             sample_clock_run,
  output logic             sum_force_zero
);
  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  trig_seq_pkg::seq_cfg_s cfg_q, cfg_d;
  logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        arm_cmd, abort_cmd, page_q, page_d;
  logic [31:0] status_word;
  logic [15:0] trig_done_q, trig_done_d;
  trig_seq_pkg::seq_state_e state_q, state_d;

  function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge24 = {be[2] ? wd[23:16] : old[23:16], be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Read address bit 4 selects the upper page, and writes use bit 4 of the last read; the page is read-only except for the trigger total,
  // so the control page stays writable at 0x00..0x0c.
  assign status_word = {8'h00, trig_done_q, 5'h00, (state_q == trig_seq_pkg::ST_IDLE),
                        sample_clock_run, acquisition_ready_out};

  always_comb begin
    cfg_d     = cfg_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    page_d    = page_q;
    arm_cmd   = 1'b0;
    abort_cmd = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      awaddr_d  = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q) begin
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      wready_d = 1'b0;
    end
    if (!awready_q && !wready_q && !bvalid_q) begin
      bvalid_d = 1'b1;
      bresp_d  = `RESP_OKAY;
      case (awaddr_q)
        `OFS_CONTROL: begin
          if (wstrb_q[0]) begin
            cfg_d.resync = wdata_q[`CTRL_RESYNC_BIT];
            cfg_d.dual   = wdata_q[`CTRL_DUAL_BIT];
            arm_cmd      = wdata_q[`CTRL_ARM_BIT];
            abort_cmd    = wdata_q[`CTRL_ABORT_BIT];
          end
        end
        `OFS_START_DELAY: cfg_d.post_trigger_sample_delay = merge24(cfg_q.post_trigger_sample_delay, wdata_q, wstrb_q);
        `OFS_STOP_DELAY:  cfg_d.rate_limit_hold_delay = merge24(cfg_q.rate_limit_hold_delay, wdata_q, wstrb_q);
        `OFS_ACQ_LENGTH:  cfg_d.acq_length = merge24(cfg_q.acq_length, wdata_q, wstrb_q);
        default:          bresp_d = `RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = `RESP_OKAY;
      page_d    = s_axi_araddr[4];
      if (!s_axi_araddr[4]) begin
        case (s_axi_araddr[3:0])
          `OFS_CONTROL:     rdata_d = {28'h0000000, 1'b0, cfg_q.dual, cfg_q.resync, 1'b0};
          `OFS_START_DELAY: rdata_d = {8'h00, cfg_q.post_trigger_sample_delay};
          `OFS_STOP_DELAY:  rdata_d = {8'h00, cfg_q.rate_limit_hold_delay};
          `OFS_ACQ_LENGTH:  rdata_d = {8'h00, cfg_q.acq_length};
          default: begin
            rdata_d = 32'h00000000;
            rresp_d = `RESP_SLVERR;
          end
        endcase
      end else begin
        case (s_axi_araddr[3:0])
          `OFS_TRIG_TOTAL: rdata_d = {16'h0000, cfg_q.trig_total};
          `OFS_STATUS:     rdata_d = status_word;
          default: begin
            rdata_d = 32'h00000000;
            rresp_d = `RESP_SLVERR;
          end
        endcase
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    // The trigger total lives on the upper page but is written there too.
    if (!awready_q && !wready_q && !bvalid_q && awaddr_q == `OFS_TRIG_TOTAL && wstrb_q[1:0] == 2'h3
        && page_q == 1'b1) begin
      cfg_d.trig_total = wdata_q[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= '{1'b0, 1'b0, `RST_START_DELAY, `RST_STOP_DELAY, `RST_ACQ_LENGTH, `RST_TRIG_TOTAL};
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h00000000;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      page_q    <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      page_q    <= page_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ----------------------------------------------------------------
  // Trigger sequencer
  // ----------------------------------------------------------------
  logic        trig_prev_q, trig_edge, trig_edge_d, trig_edge_q, trig_evt;
  logic [23:0] dly_q, dly_d, samp_q, samp_d;
  logic        ready_q, ready_d, tout_q, tout_d, run_q, run_d, zero_q, zero_d, zero_req_q, zero_req_d;
  logic [3:0]  zero_lim;

  assign trig_edge = trigger_in && !trig_prev_q;
  // An edge that lands while the stop delay ends must not be replayed once the block is armed.
  assign trig_edge_d = trig_edge && (state_q == trig_seq_pkg::ST_ARMED);
  // Resync waits for the next sample tick, trading one clock of latency for fixed alignment.
  assign trig_evt  = cfg_q.resync ? trig_edge_q : trig_edge;
  assign zero_lim  = cfg_q.dual ? `ZERO_PTS_DUAL : `ZERO_PTS_SINGLE;

  always_comb begin
    state_d     = state_q;
    dly_d       = dly_q;
    samp_d      = samp_q;
    trig_done_d = trig_done_q;
    zero_req_d  = zero_req_q;
    tout_d      = 1'b0;
    case (state_q)
      trig_seq_pkg::ST_IDLE: begin
        if (arm_cmd) begin
          state_d     = trig_seq_pkg::ST_ARMED;
          trig_done_d = 16'h0000;
        end
      end
      trig_seq_pkg::ST_ARMED: begin
        // No timer runs here: the block stays armed until a trigger or an abort comes.
        if (trig_evt) begin
          tout_d     = 1'b1;
          zero_req_d = (cfg_q.post_trigger_sample_delay == 24'h000000);
          dly_d      = cfg_q.post_trigger_sample_delay;
          samp_d     = 24'h000000;
          state_d    = zero_req_d ? trig_seq_pkg::ST_SAMPLING : trig_seq_pkg::ST_START_WAIT;
        end
      end
      trig_seq_pkg::ST_START_WAIT: begin
        dly_d = dly_q - 24'h000001;
        if (dly_q == 24'h000001) begin
          state_d = trig_seq_pkg::ST_SAMPLING;
        end
      end
      trig_seq_pkg::ST_SAMPLING: begin
        samp_d = samp_q + 24'h000001;
        if (samp_d >= cfg_q.acq_length) begin
          trig_done_d = trig_done_q + 16'h0001;
          dly_d       = cfg_q.rate_limit_hold_delay;
          if (cfg_q.rate_limit_hold_delay != 24'h000000) begin
            state_d = trig_seq_pkg::ST_STOP_WAIT;
          end else if (trig_done_d < cfg_q.trig_total) begin
            state_d = trig_seq_pkg::ST_ARMED;
          end else begin
            state_d = trig_seq_pkg::ST_IDLE;
          end
        end
      end
      trig_seq_pkg::ST_STOP_WAIT: begin
        dly_d = dly_q - 24'h000001;
        if (dly_q == 24'h000001) begin
          state_d = (trig_done_q < cfg_q.trig_total) ? trig_seq_pkg::ST_ARMED : trig_seq_pkg::ST_IDLE;
        end
      end
      default: state_d = trig_seq_pkg::ST_IDLE;
    endcase
    if (abort_cmd) begin
      state_d = trig_seq_pkg::ST_IDLE;
    end
    ready_d = (state_d == trig_seq_pkg::ST_ARMED);
    run_d   = (state_d == trig_seq_pkg::ST_SAMPLING);
    zero_d  = run_d && zero_req_d && (samp_d < {20'h00000, zero_lim});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= trig_seq_pkg::ST_IDLE;
      trig_prev_q <= 1'b0;
      trig_edge_q <= 1'b0;
      dly_q       <= 24'h000000;
      samp_q      <= 24'h000000;
      trig_done_q <= 16'h0000;
      zero_req_q  <= 1'b0;
      ready_q     <= 1'b0;
      tout_q      <= 1'b0;
      run_q       <= 1'b0;
      zero_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      trig_prev_q <= trigger_in;
      trig_edge_q <= trig_edge_d;
      dly_q       <= dly_d;
      samp_q      <= samp_d;
      trig_done_q <= trig_done_d;
      zero_req_q  <= zero_req_d;
      ready_q     <= ready_d;
      tout_q      <= tout_d;
      run_q       <= run_d;
      zero_q      <= zero_d;
    end
  end

  assign acquisition_ready_out = ready_q;
  assign trigger_out           = tout_q;
  assign sample_clock_run      = run_q;
  assign sum_force_zero        = zero_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_arm_to_ready: assert property ((state_q == trig_seq_pkg::ST_IDLE && arm_cmd && !abort_cmd)
    |=> acquisition_ready_out) else $error("Ready did not rise after arm.");
  chk_ready_means_armed: assert property (acquisition_ready_out |-> state_q == trig_seq_pkg::ST_ARMED)
    else $error("Ready high outside armed state.");
  chk_trigger_drops_ready: assert property ((acquisition_ready_out && trig_evt) |=> !acquisition_ready_out && trigger_out)
    else $error("Trigger did not drop ready or pulse output.");
  chk_ready_low_running: assert property (sample_clock_run |-> !acquisition_ready_out)
    else $error("Ready high while sampling.");
  chk_armed_holds: assert property ((acquisition_ready_out && !trig_evt && !abort_cmd) |=> acquisition_ready_out)
    else $error("Armed state left without trigger.");
  chk_trig_out_pulse: assert property (trigger_out |=> !trigger_out)
    else $error("Trigger output longer than one cycle.");
  chk_trig_out_lag: assert property (trigger_out |-> $past(trig_evt, `TRIG_OUT_CYC))
    else $error("Trigger output not one cycle after trigger.");
  chk_start_delay: assert property ((state_q == trig_seq_pkg::ST_START_WAIT && dly_q == 24'h000001 && !abort_cmd)
    |=> sample_clock_run) else $error("Sampling did not start at end of delay.");
  chk_zero_points: assert property ((trigger_out && zero_req_q && !cfg_q.dual) |-> sum_force_zero [*2])
    else $error("First points not forced to zero.");
  chk_resync_lag: assert property ((cfg_q.resync && state_q == trig_seq_pkg::ST_ARMED && trig_edge && !abort_cmd)
    |=> state_q == trig_seq_pkg::ST_ARMED) else $error("Resync trigger not delayed.");
  chk_busy_ignores: assert property ((state_q == trig_seq_pkg::ST_STOP_WAIT) |-> !acquisition_ready_out && !trigger_out)
    else $error("Trigger accepted during stop delay.");

  cov_zero_delay: cover property (trigger_out && zero_req_q);
  cov_stop_delay: cover property (state_q == trig_seq_pkg::ST_STOP_WAIT ##1 acquisition_ready_out);
  cov_resync_run: cover property (cfg_q.resync && trigger_out ##[1:20] sample_clock_run);
endmodule // trigger_arm_delay_sequencer

// file: shared/trig_seq_regs.svh
// Register offsets, field positions, reset values and timing counts of the trigger sequencer.
`ifndef TRIG_SEQ_REGS_SVH
`define TRIG_SEQ_REGS_SVH
`define OFS_CONTROL      4'h0
`define OFS_START_DELAY  4'h4
`define OFS_STOP_DELAY   4'h8
`define OFS_ACQ_LENGTH   4'hc
`define OFS_TRIG_TOTAL   4'h0
`define OFS_STATUS       4'h4
`define CTRL_ARM_BIT     0
`define CTRL_RESYNC_BIT  1
`define CTRL_DUAL_BIT    2
`define CTRL_ABORT_BIT   3
`define RST_START_DELAY  24'h000000
`define RST_STOP_DELAY   24'h000000
`define RST_ACQ_LENGTH   24'h000020
`define RST_TRIG_TOTAL   16'h0001
`define ZERO_PTS_SINGLE  4'ha
`define ZERO_PTS_DUAL    4'h5
`define CLK_PERIOD_NS    50
`define TRIG_OUT_NS      10
`define TRIG_OUT_CYC     (((`TRIG_OUT_NS) / (`CLK_PERIOD_NS)) < 1 ? 1 : ((`TRIG_OUT_NS) / (`CLK_PERIOD_NS)))
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// file: shared/trig_seq_pkg.sv
// Types shared by the trigger sequencer: sequence states and the configuration bundle.
package trig_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_START_WAIT,
    ST_SAMPLING,
    ST_STOP_WAIT
  } seq_state_e;

  typedef struct packed {
    logic        resync;
    logic        dual;
    logic [23:0] post_trigger_sample_delay;
    logic [23:0] rate_limit_hold_delay;
    logic [23:0] acq_length;
    logic [15:0] trig_total;
  } seq_cfg_s;
endpackage

// file: bench/trig_source.sv
// Behavioural model of the external trigger source and the event it fires.
`timescale 1ns/10ps
module trig_source (
  input  wire logic       aclk,
  input  wire logic       acquisition_ready_out,
  input  wire logic [9:0] fire_wait,
  input  wire logic       spurious,
  output logic            trigger_in
);
  logic [9:0] cnt_q;
  logic [2:0] hi_q;

  initial begin
    trigger_in = 1'b0;
    cnt_q      = 10'h000;
    hi_q       = 3'h0;
  end

  // The spurious mode ignores ready on purpose, to show that stray pulses are dropped.
  always @(posedge aclk) begin
    if (hi_q != 3'h0) begin
      hi_q       <= hi_q - 3'h1;
      trigger_in <= (hi_q > 3'h1);
      cnt_q      <= 10'h000;
    end else if (spurious ? (cnt_q >= 10'h004) : (acquisition_ready_out && cnt_q >= fire_wait)) begin
      trigger_in <= 1'b1;
      hi_q       <= 3'h3;
    end else begin
      cnt_q <= (acquisition_ready_out || spurious) ? cnt_q + 10'h001 : 10'h000;
    end
  end
endmodule // trig_source

// file: bench/tb_top.sv
// Self-checking bench for the trigger arm and delay sequencer.
`timescale 1ns/10ps
module tb_top;
  logic        aclk, aresetn, trigger_in, acquisition_ready_out, trigger_out, sample_clock_run, sum_force_zero;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [4:0]  s_axi_araddr;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, spurious, tin_q, run_q, rdy_q, pend;
  logic [9:0]  fire_wait;
  int          n_mismatch, tests_run, cyc, t_in, t_out, t_fall, run_len, zeros, n_tout, shots, seed;
  int          exp_d, exp_l, exp_s, exp_z, exp_lag;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w && s_axi_wready) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0; s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    check(s_axi_rdata & m, exp);
    check(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // Two shots per armed run, since the trigger total is set to two.
  task shot(input int d, input int l, input int s, input int dl, input int rs, input int fw, input int sp);
    exp_d = d; exp_l = l; exp_s = s; exp_lag = rs ? 2 : 1;
    exp_z = (d == 0) ? (dl ? 5 : 10) : 0;
    fire_wait <= fw[9:0]; spurious <= sp[0];
    wr(4'h4, d, 4'hf, 2'h0); wr(4'h8, s, 4'hf, 2'h0); wr(4'hc, l, 4'hf, 2'h0);
    rd(5'h04, d, 32'hffffff, 2'h0);
    shots = 0; n_tout = 0; pend = 1'b0;
    wr(4'h0, {29'h0, dl[0], rs[0], 1'b1}, 4'h1, 2'h0);
    while (shots < 2) @(posedge aclk);
    repeat (12) @(posedge aclk);
    check(n_tout, 2);
    rd(5'h14, 32'h4, 32'h4, 2'h0);
  endtask

  trigger_arm_delay_sequencer u_trigger_arm_delay_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_in, .acquisition_ready_out, .trigger_out,
    .sample_clock_run, .sum_force_zero);
  trig_source u_trig_source (.aclk, .acquisition_ready_out, .fire_wait, .spurious, .trigger_in);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Monitor: latencies and lengths are measured in sampled edges.
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (trigger_in === 1'b1 && !tin_q && acquisition_ready_out === 1'b1) t_in = cyc;
    if (trigger_out === 1'b1) begin
      check(cyc - t_in, exp_lag);
      check(acquisition_ready_out, 1'b0);
      t_out = cyc;
      n_tout++;
    end
    if (sample_clock_run === 1'b1 && !run_q) begin
      check(cyc - t_out, exp_d);
      run_len = 0;
      zeros = 0;
    end
    if (sample_clock_run === 1'b1) begin
      run_len++;
      zeros += (sum_force_zero === 1'b1);
      check(acquisition_ready_out, 1'b0);
    end
    if (sample_clock_run === 1'b0 && run_q) begin
      check(run_len, exp_l);
      check(zeros, exp_z);
      t_fall = cyc;
      shots++;
      pend = shots[0];
    end
    if (acquisition_ready_out === 1'b1 && !rdy_q && pend) begin
      check(cyc - t_fall >= exp_s && cyc - t_fall <= exp_s + 2, 1'b1);
      pend = 1'b0;
    end
    tin_q = trigger_in; run_q = sample_clock_run; rdy_q = acquisition_ready_out;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    seed = 32'h7c8f; aresetn = 1'b0; s_axi_awaddr = 4'h0; s_axi_wstrb = 4'h0; s_axi_wdata = 32'h0;
    s_axi_araddr = 5'h00; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; fire_wait = 10'h000; spurious = 1'b0; tin_q = 1'b0; run_q = 1'b0; rdy_q = 1'b0;
    pend = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    spurious <= 1'b1;
    rd(5'h0c, 32'h20, 32'hffffff, 2'h0); rd(5'h08, 32'h0, 32'hffffff, 2'h0); rd(5'h04, 32'h0, 32'hffffff, 2'h0);
    rd(5'h14, 32'h4, 32'h7, 2'h0);
    rd(5'h18, 32'h0, 32'hffffffff, 2'h2);
    check(n_tout, 0);
    spurious <= 1'b0;
    rd(5'h10, 32'h1, 32'hffff, 2'h0); wr(4'h0, 32'h2, 4'h3, 2'h0); rd(5'h10, 32'h2, 32'hffff, 2'h0);
    rd(5'h00, 32'h0, 32'h1, 2'h0);
    shot(0, 16, 0, 0, 0, 0, 0);
    shot(0, 16, 3, 1, 1, 0, 0);
    shot(5, 20, 7, 0, 1, 300, 0);
    shot(1, 1, 0, 0, 0, 2, 1);
    for (int i = 0; i < 6; i++) begin
      shot($unsigned($random(seed)) % 9, 16 + $unsigned($random(seed)) % 16, $unsigned($random(seed)) % 9,
           $random(seed) & 1, $random(seed) & 1, $unsigned($random(seed)) % 20, $random(seed) & 1);
    end
    fire_wait <= 10'h3ff; spurious <= 1'b0; n_tout = 0;
    wr(4'h0, 32'h1, 4'h1, 2'h0);
    repeat (3) @(posedge aclk);
    check(acquisition_ready_out, 1'b1);
    wr(4'h0, 32'h8, 4'h1, 2'h0);
    repeat (2) @(posedge aclk);
    check(acquisition_ready_out, 1'b0);
    check(n_tout, 0);
    conclude();
  end
endmodule // tb_top
